// ---- hdl/asp_pkg.sv ----
// constants for the converter serial port
package asp_pkg;
  localparam logic [3:0] CTRL_LAST = 4'h7;
  localparam logic [3:0] TRACK_AT = 4'h5;
  localparam logic [3:0] STROBE_AT = 4'h1;
  localparam logic [3:0] MSB_AT = 4'h3;
  localparam logic [3:0] FRAME_LAST = 4'hf;
  localparam logic [4:0] CONV_CYCLES = 5'h0f;
  localparam int UNIPOLAR_BIT = 3;
  localparam int LEAD_ZEROS = 3;
  localparam int TAIL_BITS = 3;
  localparam int FRAME_BITS = 16;
  typedef enum logic [1:0] {
    ASP_HUNT,
    ASP_CTRL,
    ASP_DATA
  } asp_state_type;
endpackage

// ---- hdl/asp_serial_port.sv ----
// serial port of a multichannel converter, sampled on the core clock
`timescale 1ns/1ps
module asp_serial_port #(
  parameter int RESULT_BITS = 10
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdata_in,
  input wire logic power_off_n_in,
  input wire logic [RESULT_BITS-1:0] analog_code_in,
  output logic sdata_out,
  output logic sdata_oe_out,
  output logic conversion_strobe_out,
  output logic conversion_strobe_oe_out,
  output logic track_out,
  output logic hold_out,
  output logic shutdown_out
);
  // ==========================================================
  // elaboration check
  if (RESULT_BITS + asp_pkg::LEAD_ZEROS + asp_pkg::TAIL_BITS != asp_pkg::FRAME_BITS) begin : g_chk
    $error("RESULT_BITS must fill a 16-bit frame");
  end

  // ==========================================================
  // pin synchronisers
  logic sclk_meta, sclk_sync, sclk_prev;
  logic cs_meta, cs_sync;
  logic din_meta, din_sync;
  logic pwr_meta, pwr_sync;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
      pwr_meta <= 1'b0;
      pwr_sync <= 1'b0;
    end else begin
      sclk_meta <= sclk_in;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      cs_meta <= cs_n_in;
      cs_sync <= cs_meta;
      din_meta <= sdata_in;
      din_sync <= din_meta;
      pwr_meta <= power_off_n_in;
      pwr_sync <= pwr_meta;
    end
  end
  logic rise, fall;
  assign rise = sclk_sync & ~sclk_prev;
  assign fall = ~sclk_sync & sclk_prev;

  // ==========================================================
  // frame bit selection
  function automatic logic frame_bit(input logic [RESULT_BITS-1:0] res, input logic [3:0] idx);
    logic [asp_pkg::FRAME_BITS-1:0] word;
    word = {{asp_pkg::LEAD_ZEROS{1'b0}}, res, {asp_pkg::TAIL_BITS{1'b0}}};
    return word[4'hf - idx];
  endfunction

  // ==========================================================
  // frame state
  asp_pkg::asp_state_type state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] ctrl_shift, next_ctrl_shift;
  logic [RESULT_BITS-1:0] result, next_result;
  logic sdata, next_sdata;
  logic strobe, next_strobe;
  logic track, next_track;
  logic hold, next_hold;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_ctrl_shift = ctrl_shift;
    next_result = result;
    next_sdata = sdata;
    next_strobe = strobe;
    next_track = track;
    next_hold = hold;
    if (!pwr_sync || cs_sync) begin
      // shutdown or deselect drops the frame and starts a new hunt
      next_state = asp_pkg::ASP_HUNT;
      next_bit_cnt = 4'h0;
      next_ctrl_shift = 8'h00;
      next_sdata = 1'b0;
      next_strobe = 1'b0;
      next_track = 1'b0;
      next_hold = 1'b0;
    end else if (rise) begin
      case (state)
        asp_pkg::ASP_HUNT: begin
          next_sdata = 1'b0;
          if (din_sync) begin
            next_ctrl_shift = 8'h01;
            next_bit_cnt = 4'h1;
            next_state = asp_pkg::ASP_CTRL;
          end
        end
        asp_pkg::ASP_CTRL: begin
          next_ctrl_shift = {ctrl_shift[6:0], din_sync};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == asp_pkg::CTRL_LAST) begin
            next_bit_cnt = 4'h0;
            next_state = asp_pkg::ASP_DATA;
          end
        end
        asp_pkg::ASP_DATA: begin
          next_sdata = frame_bit(result, bit_cnt);
          next_strobe = (bit_cnt == asp_pkg::STROBE_AT);
          next_bit_cnt = bit_cnt + 4'h1;
          // conversion ends after a fixed count of serial clock rises
          if (bit_cnt == asp_pkg::CONV_CYCLES[3:0] - 4'h1) begin
            next_hold = 1'b0;
          end
          // bits clocked in during readout are not parsed
          if (bit_cnt == asp_pkg::FRAME_LAST) begin
            next_state = asp_pkg::ASP_HUNT;
          end
        end
        default: begin
          next_state = asp_pkg::ASP_HUNT;
        end
      endcase
    end else if (fall) begin
      if (state == asp_pkg::ASP_CTRL && bit_cnt == asp_pkg::TRACK_AT) begin
        next_track = 1'b1;
      end
      if (state == asp_pkg::ASP_DATA && bit_cnt == 4'h0 && track) begin
        next_track = 1'b0;
        next_hold = 1'b1;
        if (ctrl_shift[asp_pkg::UNIPOLAR_BIT]) begin
          next_result = analog_code_in;
        end else begin
          next_result = {~analog_code_in[RESULT_BITS-1], analog_code_in[RESULT_BITS-2:0]};
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= asp_pkg::ASP_HUNT;
      bit_cnt <= 4'h0;
      ctrl_shift <= 8'h00;
      result <= '0;
      sdata <= 1'b0;
      strobe <= 1'b0;
      track <= 1'b0;
      hold <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      ctrl_shift <= next_ctrl_shift;
      result <= next_result;
      sdata <= next_sdata;
      strobe <= next_strobe;
      track <= next_track;
      hold <= next_hold;
    end
  end

  // ==========================================================
  // outputs; pins released while deselected
  assign sdata_out = sdata;
  assign conversion_strobe_out = strobe;
  assign sdata_oe_out = ~cs_sync;
  assign conversion_strobe_oe_out = ~cs_sync;
  assign track_out = track;
  assign hold_out = hold;
  assign shutdown_out = ~pwr_sync;

  // ==========================================================
  // checks
  logic [4:0] conv_rises;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      conv_rises <= 5'h00;
    end else if (hold) begin
      conv_rises <= conv_rises + {4'h0, rise};
    end else begin
      conv_rises <= 5'h00;
    end
  end
  logic active;
  assign active = pwr_sync & ~cs_sync;

  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_strobe_edge;
    active && rise && state == asp_pkg::ASP_DATA && bit_cnt == asp_pkg::STROBE_AT;
  endsequence
  // the next rise cannot come one core cycle after the launching one
  sequence s_strobe_held;
    strobe ##1 (strobe || !$past(active));
  endsequence

  property p_release;
    cs_sync |-> !sdata_oe_out && !conversion_strobe_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("pins driven while deselected");

  property p_launch_on_rise;
    $changed(sdata) |-> $past(rise) || !$past(active);
  endproperty
  a_launch_on_rise: assert property (p_launch_on_rise) else $error("data moved off a rise");

  property p_capture;
    active && rise && state == asp_pkg::ASP_CTRL |=> ctrl_shift[0] == $past(din_sync);
  endproperty
  a_capture: assert property (p_capture) else $error("input bit not captured");

  property p_no_shift_deselected;
    cs_sync |=> state == asp_pkg::ASP_HUNT && ctrl_shift == 8'h00;
  endproperty
  a_no_shift_deselected: assert property (p_no_shift_deselected) else $error("shift while deselected");

  property p_strobe_one_period;
    s_strobe_edge |=> s_strobe_held;
  endproperty
  a_strobe_one_period: assert property (p_strobe_one_period) else $error("strobe width wrong");

  // strobe ends at the first rise after it was raised
  property p_strobe_drop;
    strobe && rise && active |=> !strobe;
  endproperty
  a_strobe_drop: assert property (p_strobe_drop) else $error("strobe outlived its period");

  property p_strobe_cause;
    $rose(strobe) |-> $past(state) == asp_pkg::ASP_DATA && $past(bit_cnt) == asp_pkg::STROBE_AT;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe at wrong bit");

  property p_shutdown;
    !pwr_sync |-> shutdown_out ##1 (state == asp_pkg::ASP_HUNT && !track && !hold);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown ignored");

  property p_conv_len;
    $fell(hold) && active && $past(active) |-> conv_rises == asp_pkg::CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_start_bit;
    active && rise && state == asp_pkg::ASP_HUNT && din_sync
      |=> state == asp_pkg::ASP_CTRL && ctrl_shift == 8'h01;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit missed");

  property p_hold_after_eight;
    active && fall && track && state == asp_pkg::ASP_DATA && bit_cnt == 4'h0 |=> hold && !track;
  endproperty
  a_hold_after_eight: assert property (p_hold_after_eight) else $error("hold late");

  property p_msb_out;
    active && rise && state == asp_pkg::ASP_DATA && bit_cnt == asp_pkg::MSB_AT
      |=> sdata == result[RESULT_BITS-1];
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("msb not on line");

  property p_coding;
    $rose(hold) |-> result[RESULT_BITS-2:0] == $past(analog_code_in[RESULT_BITS-2:0]) &&
      result[RESULT_BITS-1] == ($past(analog_code_in[RESULT_BITS-1]) ^
      !ctrl_shift[asp_pkg::UNIPOLAR_BIT]);
  endproperty
  a_coding: assert property (p_coding) else $error("result coding wrong");
endmodule

// ---- bench/asp_host_model.sv ----
// host master model that clocks frames through the converter serial port
`timescale 1ns/1ps
module asp_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdata_out,
  input wire logic dout_in,
  input wire logic dout_oe_in,
  input wire logic strobe_in,
  input wire logic track_in,
  input wire logic hold_in
);
  logic [15:0] rx;
  logic [15:0] strb;
  logic [23:0] trk;
  logic [23:0] hld;
  logic last;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdata_out = 1'b0;
    last = 1'b0;
  end
  // ==========================================================
  // frame: lead zeros, control byte, 16 readout rises
  // ends early after abort_at rises; clock idles low between frames
  task automatic frame(input logic [7:0] ctrl, input int lead, input int abort_at);
    int n;
    int j;
    rx = '0;
    strb = '0;
    trk = '0;
    hld = '0;
    cs_n_out = 1'b0;
    #63;
    for (n = 0; n < lead + 24 && n < abort_at; n++) begin
      if (n < lead) sdata_out = 1'b0;
      else if (n < lead + 8) sdata_out = ctrl[7 - (n - lead)];
      else sdata_out = ~sdata_out; // ignored bits, so keep them moving
      #40;
      if (n >= lead) begin
        trk[n - lead] = track_in;
        hld[n - lead] = hold_in;
      end
      sclk_out = 1'b1; // 50% duty keeps inside 40..60
      #62.5;
      sclk_out = 1'b0;
      j = n - lead - 8;
      if (j >= 0) begin
        // undriven wire shows the inverse of the last level seen
        rx[15 - j] = dout_oe_in ? dout_in : ~last;
        last = rx[15 - j];
        strb[15 - j] = strobe_in;
      end
      #22.5;
    end
    #40;
    cs_n_out = 1'b1;
    sdata_out = ~sdata_out;
    #250;
  endtask
endmodule

// ---- bench/test_adc_serial_port.sv ----
// self-checking testbench for the converter serial port
`timescale 1ns/1ps
module test_adc_serial_port;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic power_off_n = 1'b1;
  logic [9:0] analog_code = 10'h000;
  logic sclk, cs_n, din, dout, dout_oe, strobe, strobe_oe, track, hold, shutdown;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h00011c25;
  logic [7:0] ctrl;
  always #4 core_clk_in = ~core_clk_in;
  asp_serial_port #(.RESULT_BITS(10)) asp_serial_port_i (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .sdata_in(din),
    .power_off_n_in(power_off_n), .analog_code_in(analog_code), .sdata_out(dout),
    .sdata_oe_out(dout_oe), .conversion_strobe_out(strobe),
    .conversion_strobe_oe_out(strobe_oe), .track_out(track), .hold_out(hold),
    .shutdown_out(shutdown));
  asp_host_model asp_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .sdata_out(din),
    .dout_in(dout), .dout_oe_in(dout_oe), .strobe_in(strobe), .track_in(track),
    .hold_in(hold));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // bipolar is the offset code with its top bit flipped
  function automatic logic [15:0] exp_word(input logic [7:0] c, input logic [9:0] a);
    return {3'h0, (c[3] ? a : {~a[9], a[8:0]}), 3'h0};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    check("shutdown idle", 32'h0, shutdown);
    check("oe idle", 32'h0, {dout_oe, strobe_oe});
    asp_host_model_i.frame(8'h8f, 1, 5);
    for (int i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      ctrl = {1'b1, seed[6:4], i[0], seed[2:0]};
      @(posedge core_clk_in);
      analog_code <= (i < 2) ? (i == 0 ? 10'h3ff : 10'h200) : seed[25:16];
      @(posedge core_clk_in);
      asp_host_model_i.frame(ctrl, int'(seed[9:8]), 100);
      check("result word", exp_word(ctrl, analog_code), asp_host_model_i.rx);
      check("coding", exp_word(ctrl, analog_code), asp_host_model_i.rx);
      check("strobe", 32'h4000, asp_host_model_i.strb);
      check("track", 32'h0000e0, asp_host_model_i.trk);
      check("hold", 32'h7fff00, asp_host_model_i.hld);
      check("oe after cs", 32'h0, {dout_oe, strobe_oe});
    end
    @(posedge core_clk_in);
    power_off_n <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    check("shutdown on", 32'h1, shutdown);
    asp_host_model_i.frame(8'hff, 0, 100);
    check("shut result", 32'h0, asp_host_model_i.rx);
    check("shut hold", 32'h0, asp_host_model_i.hld);
    @(posedge core_clk_in);
    power_off_n <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    check("shutdown off", 32'h0, shutdown);
    complete_run();
  end
  // whole run needs about 26 us; allow over seven times that
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
